// file: shared/cpu_ctrl_pkg.sv
// Address map, control word layout and sequencer types of the core control
package cpu_ctrl_pkg;

	localparam logic [15:0] VEC_BASE   = 16'h0000;
	localparam logic [15:0] VEC_END    = 16'h003f;
	localparam logic [15:0] TABLE_CALL_INSTRUCTION_BASE = 16'h0040;
	localparam logic [15:0] TABLE_CALL_INSTRUCTION_END  = 16'h007f;
	localparam logic [15:0] OPT_ADDR   = 16'h0080;
	localparam logic [15:0] FIXED_AREA_CALL_INSTRUCTION_BASE = 16'h0800;
	localparam logic [15:0] FIXED_AREA_CALL_INSTRUCTION_END  = 16'h0fff;
	localparam logic [15:0] RAM_BASE   = 16'hfc00;
	localparam logic [15:0] RAM_END    = 16'hfeff;
	localparam logic [15:0] BANK_BASE  = 16'hfee0;
	localparam logic [15:0] BANK_TOP   = 16'hfef8;
	localparam logic [15:0] SFR_BASE   = 16'hff00;
	localparam logic [15:0] SFR_END    = 16'hffff;
	localparam logic [15:0] MSS_ADDR   = 16'hfff0;

	localparam logic [7:0]  MSS_RESET  = 8'hcf;
	localparam logic [7:0]  MSS_SMALL  = 8'h02;
	localparam logic [7:0]  MSS_LARGE  = 8'h04;
	localparam logic [7:0]  PSW_RESET  = 8'h02;
	localparam logic [15:0] SP_RESET   = 16'hfee0;

	localparam int PSW_IE   = 7;
	localparam int PSW_RBS1 = 5;
	localparam int PSW_RBS0 = 3;

	// One bit per two-byte vector slot; clear bits have no source
	localparam logic [31:0] VALID_SLOTS = 32'h67f0797c;

	localparam int DBG_BYTES_DEF = 256;
	localparam int DBG_BYTES_MIN = 256;
	localparam int DBG_BYTES_MAX = 1024;

	typedef enum logic [1:0] {
		RG_NONE,
		RG_FLASH,
		RG_RAM,
		RG_SFR
	} region_t;

	typedef enum logic [1:0] {
		AC_FETCH,
		AC_DATA,
		AC_STACK
	} access_t;

	typedef enum logic [2:0] {
		TG_NONE,
		TG_PCL,
		TG_PCH,
		TG_PSW,
		TG_OPT,
		TG_DATA
	} tag_t;

	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_OPT      = 4'h1,
		ST_VEC_LO   = 4'h3,
		ST_VEC_HI   = 4'h2,
		ST_DRAIN    = 4'h6,
		ST_RUN      = 4'h7,
		ST_PUSH_PSW = 4'h5,
		ST_PUSH_PCH = 4'h4,
		ST_PUSH_PCL = 4'hc,
		ST_POP_PCL  = 4'hd,
		ST_POP_PCH  = 4'hf,
		ST_POP_PSW  = 4'he,
		ST_PUSHP    = 4'ha,
		ST_POPP     = 4'hb
	} state_t;

endpackage : cpu_ctrl_pkg

// file: design/mem_region_decode.sv
// Address region decoder with access permission check
`timescale 1ns/100ps

module mem_region_decode
	import cpu_ctrl_pkg::*;
#(
	parameter int DBG_BYTES = DBG_BYTES_DEF
) (
	input  wire logic [15:0] addr,
	input  wire access_t     kind,
	input  wire logic        isWrite,
	input  wire logic        debugActive,
	input  wire logic [7:0]  memSize,
	output region_t          region,
	output logic             allow
);

	if (DBG_BYTES < DBG_BYTES_MIN || DBG_BYTES > DBG_BYTES_MAX) begin : g_bad
		$error("Debug command area size out of range");
	end

	localparam logic [16:0] DBG_SIZE = 17'(DBG_BYTES);

	logic [16:0] flashSize;
	logic [16:0] dbgBase;

	// Low nibble of the size register counts 4 KB flash units
	assign flashSize = {1'b0, memSize[3:0], 12'h000};
	assign dbgBase   = flashSize - DBG_SIZE;

	always_comb begin
		region = RG_NONE;
		if (addr >= SFR_BASE) begin
			region = RG_SFR;
		end else if (addr >= RAM_BASE && addr <= RAM_END) begin
			region = RG_RAM;
		end else if ({1'b0, addr} < flashSize) begin
			region = RG_FLASH;
		end
		if (debugActive && region == RG_FLASH &&
			{1'b0, addr} >= dbgBase) begin
			region = RG_NONE;
		end
	end

	always_comb begin
		unique case (kind)
			AC_FETCH: allow = (region == RG_FLASH) && !isWrite;
			AC_STACK: allow = (region == RG_RAM);
			AC_DATA:  allow = isWrite ?
				(region == RG_RAM || region == RG_SFR) :
				(region != RG_NONE);
			default:  allow = 1'b0;
		endcase
	end

endmodule : mem_region_decode

// file: design/cpu_control_core.sv
// Core control: program counter, status word, stack and memory access
`timescale 1ns/100ps

// Overview of operation
// - One flat 64 KB space holds flash, RAM and peripheral registers.
// - Bytes 0000H to 003FH hold reset and interrupt start addresses.
// - Vector low byte sits at the even address, high byte next.
// - Every reset source starts through the vector at 0000H.
// - Vector slots without a source are never used for interrupts.
// - Table call reads its entry address from 0040H to 007FH.
// - Byte 0080H is the option byte that configures the device.
// - Fixed-area call reaches any subroutine in 0800H to 0FFFH.
// - Internal high-speed RAM decodes at FC00H to FEFFH, 768 bytes.
// - FEE0H to FEFFH holds four banks of eight byte registers.
// - Instructions are never fetched from internal high-speed RAM.
// - Stack accesses go only to internal high-speed RAM.
// - Peripheral registers decode at FF00H to FFFFH.
// - Memory size register resets to CFH; software writes 02H or 04H.
// - During debugging a 256 byte to 1 KB command area is hidden.
// - Program counter is 16 bits and holds the next instruction address.
// - Counter adds instruction length, or loads the branch target.
// - Reset loads the counter from bytes 0000H and 0001H.
// - Status word is eight bits of flags set by instructions.
// - Status word is pushed on interrupt entry and by push-status.
// - Interrupt return, break return and pop-status restore it.
// - Reset sets the status word to 02H.
// - Enable flag clears on acknowledge or disable, sets on enable.
// - Stack pointer decrements before a write, increments after a read.
module cpu_control_core
	import cpu_ctrl_pkg::*;
#(
	parameter int DBG_BYTES = DBG_BYTES_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        fetchReq,
	input  wire logic [2:0]  fetchOffset,
	input  wire logic        dataReq,
	input  wire logic        dataWrite,
	input  wire logic [15:0] dataAddr,
	input  wire logic [7:0]  dataWdata,
	output logic      [7:0]  rdData,
	output logic             rdValid,
	output logic             accessFault,
	input  wire logic        instrDone,
	input  wire logic [2:0]  instrLen,
	input  wire logic        branchLoad,
	input  wire logic [15:0] branchTarget,
	input  wire logic        flagWe,
	input  wire logic [7:0]  flagData,
	input  wire logic        eiCmd,
	input  wire logic        diCmd,
	input  wire logic        pushPswCmd,
	input  wire logic        popPswCmd,
	input  wire logic        intRetCmd,
	input  wire logic        brkRetCmd,
	input  wire logic        callTableCmd,
	input  wire logic [4:0]  callTableIndex,
	input  wire logic        callFixedCmd,
	input  wire logic [10:0] callFixedOffset,
	input  wire logic        spLoad,
	input  wire logic [15:0] spData,
	input  wire logic        intReq,
	input  wire logic [4:0]  intSlot,
	output logic             intAck,
	input  wire logic        debugActive,
	output logic      [15:0] memAddr,
	output logic             memRe,
	output logic             memWe,
	output logic      [7:0]  memWdata,
	input  wire logic [7:0]  memRdata,
	output logic             selFlash,
	output logic             selRam,
	output logic             selSfr,
	output logic      [15:0] pc,
	output logic      [7:0]  program_status_word,
	output logic      [15:0] sp,
	output logic      [7:0]  memSize,
	output logic      [7:0]  optionByte,
	output logic      [15:0] bankBase,
	output logic             stackFault,
	output logic             busy
);

	state_t      state_q,    state_d;
	logic [15:0] pc_q,       pc_d;
	logic [7:0]  psw_q,      psw_d;
	logic [15:0] sp_q,       sp_d;
	logic [7:0]  memSize_q,  memSize_d;
	logic [7:0]  option_q,   option_d;
	logic [15:0] vecAddr_q,  vecAddr_d;
	logic        direct_q,   direct_d;
	tag_t        tag1_q,     tag1_d;
	tag_t        tag2_q,     tag2_d;
	logic [15:0] memAddr_q,  memAddr_d;
	logic        memRe_q,    memRe_d;
	logic        memWe_q,    memWe_d;
	logic [7:0]  memWd_q,    memWd_d;
	logic        selFl_q,    selFl_d;
	logic        selRam_q,   selRam_d;
	logic        selSfr_q,   selSfr_d;
	logic [7:0]  rdData_q,   rdData_d;
	logic        rdValid_q,  rdValid_d;
	logic        accFault_q, accFault_d;
	logic        stkFault_q, stkFault_d;
	logic        intAck_q,   intAck_d;
	logic [15:0] bank_q,     bank_d;

	logic [15:0] busAddr;
	logic        busRe;
	logic        busWe;
	logic [7:0]  busWd;
	access_t     busKind;
	tag_t        busTag;
	region_t     busRegion;
	logic        busAllow;
	logic        quiet;

	mem_region_decode #(
		.DBG_BYTES   (DBG_BYTES)
	) u_decode (
		.addr        (busAddr),
		.kind        (busKind),
		.isWrite     (busWe),
		.debugActive (debugActive),
		.memSize     (memSize_q),
		.region      (busRegion),
		.allow       (busAllow)
	);

	// Interrupts wait for a cycle with no pc, flag, stack pointer or enable update
	assign quiet = !(instrDone || branchLoad || flagWe || spLoad ||
		eiCmd || diCmd);

	always_comb begin
		state_d   = state_q;
		pc_d      = pc_q;
		psw_d     = psw_q;
		sp_d      = sp_q;
		memSize_d = memSize_q;
		option_d  = option_q;
		vecAddr_d = vecAddr_q;
		direct_d  = direct_q;
		rdData_d  = rdData_q;
		rdValid_d = 1'b0;
		intAck_d  = 1'b0;
		busAddr   = 16'h0000;
		busRe     = 1'b0;
		busWe     = 1'b0;
		busWd     = 8'h00;
		busKind   = AC_DATA;
		busTag    = TG_NONE;

		// Read data returns two cycles after the request is decided
		unique case (tag2_q)
			TG_PCL:  pc_d[7:0]  = memRdata;
			TG_PCH:  pc_d[15:8] = memRdata;
			TG_PSW:  psw_d      = memRdata;
			TG_OPT:  option_d   = memRdata;
			TG_DATA: begin
				rdData_d  = memRdata;
				rdValid_d = 1'b1;
			end
			default: ;
		endcase

		unique case (state_q)
			ST_RESET: begin
				vecAddr_d = VEC_BASE;
				state_d   = ST_OPT;
			end
			ST_OPT: begin
				busAddr = OPT_ADDR;
				busRe   = 1'b1;
				busTag  = TG_OPT;
				state_d = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				busAddr = vecAddr_q;
				busRe   = 1'b1;
				busTag  = TG_PCL;
				state_d = ST_VEC_HI;
			end
			ST_VEC_HI: begin
				busAddr = vecAddr_q | 16'h0001;
				busRe   = 1'b1;
				busTag  = TG_PCH;
				state_d = ST_DRAIN;
			end
			ST_DRAIN: begin
				if (tag1_q == TG_NONE && tag2_q == TG_NONE) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (branchLoad) begin
					pc_d = branchTarget;
				end else if (instrDone) begin
					pc_d = pc_q + {13'h0000, instrLen};
				end
				if (flagWe) begin
					psw_d = flagData;
				end
				if (eiCmd) begin
					psw_d[PSW_IE] = 1'b1;
				end else if (diCmd) begin
					psw_d[PSW_IE] = 1'b0;
				end
				if (spLoad) begin
					sp_d = spData;
				end
				if (quiet && intReq && psw_q[PSW_IE] &&
					VALID_SLOTS[intSlot]) begin
					intAck_d  = 1'b1;
					vecAddr_d = {10'h000, intSlot, 1'b0};
					direct_d  = 1'b0;
					state_d   = ST_PUSH_PSW;
				end else if (intRetCmd || brkRetCmd) begin
					state_d = ST_POP_PCL;
				end else if (callTableCmd) begin
					vecAddr_d = TABLE_CALL_INSTRUCTION_BASE +
						{10'h000, callTableIndex, 1'b0};
					direct_d  = 1'b0;
					state_d   = ST_PUSH_PCH;
				end else if (callFixedCmd) begin
					vecAddr_d = FIXED_AREA_CALL_INSTRUCTION_BASE |
						{5'h00, callFixedOffset};
					direct_d  = 1'b1;
					state_d   = ST_PUSH_PCH;
				end else if (pushPswCmd) begin
					state_d = ST_PUSHP;
				end else if (popPswCmd) begin
					state_d = ST_POPP;
				end else if (dataReq) begin
					if (dataWrite && dataAddr == MSS_ADDR) begin
						memSize_d = dataWdata;
					end else begin
						busAddr = dataAddr;
						busRe   = !dataWrite;
						busWe   = dataWrite;
						busWd   = dataWdata;
						busTag  = dataWrite ? TG_NONE : TG_DATA;
					end
				end else if (fetchReq) begin
					busAddr = pc_q + {13'h0000, fetchOffset};
					busRe   = 1'b1;
					busKind = AC_FETCH;
					busTag  = TG_DATA;
				end
			end
			ST_PUSH_PSW: begin
				sp_d    = sp_q - 16'h0001;
				busAddr = sp_q - 16'h0001;
				busWe   = 1'b1;
				busWd   = psw_q;
				busKind = AC_STACK;
				psw_d[PSW_IE] = 1'b0;
				state_d = ST_PUSH_PCH;
			end
			ST_PUSH_PCH: begin
				sp_d    = sp_q - 16'h0001;
				busAddr = sp_q - 16'h0001;
				busWe   = 1'b1;
				busWd   = pc_q[15:8];
				busKind = AC_STACK;
				state_d = ST_PUSH_PCL;
			end
			ST_PUSH_PCL: begin
				sp_d    = sp_q - 16'h0001;
				busAddr = sp_q - 16'h0001;
				busWe   = 1'b1;
				busWd   = pc_q[7:0];
				busKind = AC_STACK;
				if (direct_q) begin
					pc_d    = vecAddr_q;
					state_d = ST_RUN;
				end else begin
					state_d = ST_VEC_LO;
				end
			end
			ST_POP_PCL: begin
				sp_d    = sp_q + 16'h0001;
				busAddr = sp_q;
				busRe   = 1'b1;
				busKind = AC_STACK;
				busTag  = TG_PCL;
				state_d = ST_POP_PCH;
			end
			ST_POP_PCH: begin
				sp_d    = sp_q + 16'h0001;
				busAddr = sp_q;
				busRe   = 1'b1;
				busKind = AC_STACK;
				busTag  = TG_PCH;
				state_d = ST_POP_PSW;
			end
			ST_POP_PSW: begin
				sp_d    = sp_q + 16'h0001;
				busAddr = sp_q;
				busRe   = 1'b1;
				busKind = AC_STACK;
				busTag  = TG_PSW;
				state_d = ST_DRAIN;
			end
			ST_PUSHP: begin
				sp_d    = sp_q - 16'h0001;
				busAddr = sp_q - 16'h0001;
				busWe   = 1'b1;
				busWd   = psw_q;
				busKind = AC_STACK;
				state_d = ST_RUN;
			end
			ST_POPP: begin
				sp_d    = sp_q + 16'h0001;
				busAddr = sp_q;
				busRe   = 1'b1;
				busKind = AC_STACK;
				busTag  = TG_PSW;
				state_d = ST_DRAIN;
			end
			default: state_d = ST_RESET;
		endcase
	end

	// Refused accesses never reach memory; a lost pop leaves the target
	always_comb begin
		memAddr_d  = busAddr;
		memWd_d    = busWd;
		memRe_d    = busRe && busAllow;
		memWe_d    = busWe && busAllow;
		tag1_d     = busAllow ? busTag : TG_NONE;
		tag2_d     = tag1_q;
		selFl_d    = (busRe || busWe) && busRegion == RG_FLASH;
		selRam_d   = (busRe || busWe) && busRegion == RG_RAM;
		selSfr_d   = (busRe || busWe) && busRegion == RG_SFR;
		accFault_d = (busRe || busWe) && !busAllow &&
			busKind != AC_STACK;
		stkFault_d = (busRe || busWe) && !busAllow &&
			busKind == AC_STACK;
		// Bank 0 is the top eight bytes, bank 3 starts at the bottom
		bank_d = BANK_TOP -
			{11'h000, psw_d[PSW_RBS1], psw_d[PSW_RBS0], 3'b000};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q    <= ST_RESET;
			pc_q       <= VEC_BASE;
			psw_q      <= PSW_RESET;
			sp_q       <= SP_RESET;
			memSize_q  <= MSS_RESET;
			option_q   <= 8'h00;
			vecAddr_q  <= VEC_BASE;
			direct_q   <= 1'b0;
			tag1_q     <= TG_NONE;
			tag2_q     <= TG_NONE;
			memAddr_q  <= 16'h0000;
			memRe_q    <= 1'b0;
			memWe_q    <= 1'b0;
			memWd_q    <= 8'h00;
			selFl_q    <= 1'b0;
			selRam_q   <= 1'b0;
			selSfr_q   <= 1'b0;
			rdData_q   <= 8'h00;
			rdValid_q  <= 1'b0;
			accFault_q <= 1'b0;
			stkFault_q <= 1'b0;
			intAck_q   <= 1'b0;
			bank_q     <= BANK_TOP;
		end else if (ce) begin
			state_q    <= state_d;
			pc_q       <= pc_d;
			psw_q      <= psw_d;
			sp_q       <= sp_d;
			memSize_q  <= memSize_d;
			option_q   <= option_d;
			vecAddr_q  <= vecAddr_d;
			direct_q   <= direct_d;
			tag1_q     <= tag1_d;
			tag2_q     <= tag2_d;
			memAddr_q  <= memAddr_d;
			memRe_q    <= memRe_d;
			memWe_q    <= memWe_d;
			memWd_q    <= memWd_d;
			selFl_q    <= selFl_d;
			selRam_q   <= selRam_d;
			selSfr_q   <= selSfr_d;
			rdData_q   <= rdData_d;
			rdValid_q  <= rdValid_d;
			accFault_q <= accFault_d;
			stkFault_q <= stkFault_d;
			intAck_q   <= intAck_d;
			bank_q     <= bank_d;
		end
	end

	assign memAddr     = memAddr_q;
	assign memRe       = memRe_q;
	assign memWe       = memWe_q;
	assign memWdata    = memWd_q;
	assign selFlash    = selFl_q;
	assign selRam      = selRam_q;
	assign selSfr      = selSfr_q;
	assign rdData      = rdData_q;
	assign rdValid     = rdValid_q;
	assign accessFault = accFault_q;
	assign stackFault  = stkFault_q;
	assign intAck      = intAck_q;
	assign pc          = pc_q;
	assign program_status_word         = psw_q;
	assign sp          = sp_q;
	assign memSize     = memSize_q;
	assign optionByte  = option_q;
	assign bankBase    = bank_q;
	assign busy        = (state_q != ST_RUN);

endmodule : cpu_control_core

// file: test/mem_partner_model.sv
// Synchronous flash and RAM model behind the core's memory strobes
`timescale 1ns/100ps

module mem_partner_model (
	input  wire logic        clk,
	input  wire logic [15:0] memAddr,
	input  wire logic        memRe,
	input  wire logic        memWe,
	input  wire logic [7:0]  memWdata,
	output logic      [7:0]  memRdata
);
	logic [7:0] mem [0:65535];

	// Fill pattern is address-derived so the bench can predict every byte
	initial begin
		memRdata = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
		end
	end

	// Idle cycles show a toggling byte so a late sample cannot pass
	always @(posedge clk) begin
		if (memWe) begin
			mem[memAddr] <= memWdata;
		end
		if (memRe) begin
			memRdata <= mem[memAddr];
		end else begin
			memRdata <= ~memRdata;
		end
	end
endmodule : mem_partner_model

// file: test/cpu_control_core_monitor.sv
// Port checker for the core control block
`timescale 1ns/100ps

module cpu_control_core_monitor
	import cpu_ctrl_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        busy,
	input wire logic        instrDone,
	input wire logic [2:0]  instrLen,
	input wire logic        branchLoad,
	input wire logic [15:0] branchTarget,
	input wire logic        eiCmd,
	input wire logic        intAck,
	input wire logic [15:0] memAddr,
	input wire logic        memRe,
	input wire logic        memWe,
	input wire logic [7:0]  memWdata,
	input wire logic        selFlash,
	input wire logic        selRam,
	input wire logic        selSfr,
	input wire logic [15:0] pc,
	input wire logic [7:0]  program_status_word,
	input wire logic [15:0] sp,
	input wire logic [7:0]  memSize,
	input wire logic [15:0] bankBase,
	input wire logic        stackFault
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_values: assert property (
		$rose(rst_n) |-> program_status_word == PSW_RESET && memSize == MSS_RESET)
		else $error("reset values wrong");
	a_boot_vector: assert property (
		$rose(rst_n) |-> ##[1:4] (memRe && memAddr == OPT_ADDR)
		##1 (memRe && memAddr == 16'h0000) ##1 (memRe && memAddr == 16'h0001))
		else $error("boot read order wrong");
	a_int_push: assert property (
		intAck |=> (memWe && memAddr == sp && memWdata[PSW_IE])
		##1 !program_status_word[PSW_IE]) else $error("status not saved on interrupt");
	a_int_vector: assert property (
		intAck |-> ##[3:5] (memRe && !memAddr[0] && memAddr <= VEC_END
		&& VALID_SLOTS[memAddr[5:1]]) ##1 (memRe && memAddr[0]))
		else $error("interrupt vector read wrong");
	a_pc_step: assert property (
		instrDone && !branchLoad && !busy |=>
		pc == $past(pc) + 16'($past(instrLen))) else $error("pc step wrong");
	a_branch_load: assert property (
		branchLoad && !busy |=> pc == $past(branchTarget))
		else $error("branch load wrong");
	a_ie_set: assert property (
		eiCmd && !busy |=> program_status_word[PSW_IE]) else $error("enable flag not set");
	a_ram_window: assert property (
		selRam && (memRe || memWe) |-> memAddr >= RAM_BASE
		&& memAddr <= RAM_END) else $error("ram select outside window");
	a_sfr_window: assert property (
		selSfr && (memRe || memWe) |-> memAddr >= SFR_BASE)
		else $error("sfr select outside window");
	a_flash_size: assert property (
		selFlash && memRe |-> memAddr < {memSize[3:0], 12'h000})
		else $error("flash read beyond size");
	a_stack_refused: assert property (
		stackFault |-> !memWe && !memRe) else $error("refused stack strobed");
	a_bank_base: assert property (
		$stable(program_status_word) [*2] |-> bankBase == BANK_TOP
		- {11'h0, program_status_word[PSW_RBS1], program_status_word[PSW_RBS0], 3'h0})
		else $error("bank base wrong");
endmodule : cpu_control_core_monitor

// file: test/cpu_memory_map_control_regs_tb_top.sv
// Self-checking bench for the core control block
`timescale 1ns/100ps

module cpu_memory_map_control_regs_tb_top
	import cpu_ctrl_pkg::*;
;
	logic        clk, rst_n, ce, fetchReq, dataReq, dataWrite, intReq;
	logic        debugActive, rdValid, accessFault, intAck, memRe, memWe;
	logic        selFlash, selRam, selSfr, stackFault, busy, flt, hit;
	logic        eiCmd, diCmd, pushPswCmd, popPswCmd, intRetCmd, brkRetCmd;
	logic        callTableCmd, callFixedCmd, instrDone, branchLoad, flagWe;
	logic        spLoad;
	logic [2:0]  fetchOffset, instrLen;
	logic [4:0]  callTableIndex, intSlot;
	logic [7:0]  dataWdata, rdData, flagData, memWdata, memRdata, program_status_word, rd;
	logic [7:0]  memSize, optionByte;
	logic [10:0] callFixedOffset;
	logic [15:0] dataAddr, branchTarget, spData, memAddr, pc, sp, bankBase;
	logic [11:0] cmdV;
	int          mismatches, checkCount;

	assign {spLoad, flagWe, branchLoad, instrDone, callFixedCmd, callTableCmd,
		brkRetCmd, intRetCmd, popPswCmd, pushPswCmd, diCmd, eiCmd} = cmdV;

	cpu_control_core uut (.clk, .rst_n, .ce, .fetchReq, .fetchOffset,
		.dataReq, .dataWrite, .dataAddr, .dataWdata, .rdData, .rdValid,
		.accessFault, .instrDone, .instrLen, .branchLoad, .branchTarget,
		.flagWe, .flagData, .eiCmd, .diCmd, .pushPswCmd, .popPswCmd,
		.intRetCmd, .brkRetCmd, .callTableCmd, .callTableIndex, .callFixedCmd,
		.callFixedOffset, .spLoad, .spData, .intReq, .intSlot, .intAck,
		.debugActive, .memAddr, .memRe, .memWe, .memWdata, .memRdata,
		.selFlash, .selRam, .selSfr, .pc, .program_status_word, .sp, .memSize, .optionByte,
		.bankBase, .stackFault, .busy);
	mem_partner_model mem (.clk, .memAddr, .memRe, .memWe, .memWdata,
		.memRdata);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [7:0] expb(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction : expb

	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checkCount++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic stopTest;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stopTest

	task automatic waitIdle;
		for (int i = 0; i < 40; i++) begin
			if (busy === 1'b0) return;
			step;
		end
		mismatches++;
		$display("CHECK FAILED at %0t: busy never dropped", $time);
		stopTest;
	endtask : waitIdle

	// One-cycle pulse on a single command line; others stay untouched
	task automatic cmd(input int c);
		cmdV[c] = 1'b1;
		step;
		cmdV[c] = 1'b0;
	endtask : cmd

	// Kind 0 data read, 1 data write, 2 fetch
	task automatic access(input int k, input logic [15:0] a,
		input logic [7:0] wd);
		rd = 8'hxx;
		flt = 1'b0;
		fetchReq = (k == 2);
		dataReq = (k != 2);
		dataWrite = (k == 1);
		dataAddr = a;
		dataWdata = wd;
		for (int i = 0; i < 6; i++) begin
			step;
			if (i == 0) {fetchReq, dataReq, dataWrite} = 3'b000;
			if (accessFault === 1'b1) flt = 1'b1;
			if (rdValid === 1'b1) rd = rdData;
		end
	endtask : access

	task automatic waitf(input int w, input int n);
		hit = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (w == 0 && intAck === 1'b1) hit = 1'b1;
			if (w == 1 && stackFault === 1'b1) hit = 1'b1;
			step;
		end
	endtask : waitf

	task automatic testReset;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		waitIdle;
		chk(pc, {expb(16'h0001), expb(16'h0000)});
		chk(program_status_word, PSW_RESET);
		chk(memSize, MSS_RESET);
		chk(optionByte, expb(OPT_ADDR));
		$display("test reset done");
	endtask : testReset

	task automatic testPc;
		instrLen = 3'h3;
		cmd(8);
		chk(pc, {expb(16'h0001), expb(16'h0000)} + 16'h3);
		step;
		branchTarget = 16'h0100;
		cmdV[8] = 1'b1;
		cmd(9);
		cmdV[8] = 1'b0;
		chk(pc, 16'h0100);
		$display("test pc done");
	endtask : testPc

	task automatic testDecode;
		access(1, MSS_ADDR, MSS_SMALL);
		chk(memSize, MSS_SMALL);
		fetchOffset = 3'h2;
		access(2, 16'h0000, 8'h00);
		chk(rd, expb(16'h0102));
		access(1, 16'hfc10, 8'h3c);
		access(0, 16'hfc10, 8'h00);
		chk(rd, 8'h3c);
		// Peripheral register FF00H and the top flash byte read back
		access(0, 16'hff00, 8'h00);
		chk(rd, expb(16'hff00));
		access(0, 16'h1fff, 8'h00);
		chk(rd, expb(16'h1fff));
		// Top 256 bytes of the 8 KB flash vanish while debugging
		debugActive = 1'b1;
		access(0, 16'h1f00, 8'h00);
		chk(flt, 1'b1);
		access(0, 16'h1eff, 8'h00);
		chk(rd, expb(16'h1eff));
		debugActive = 1'b0;
		access(0, 16'h2000, 8'h00);
		chk(flt, 1'b1);
		access(1, 16'h0010, 8'h00);
		chk(flt, 1'b1);
		branchTarget = RAM_BASE;
		cmd(9);
		access(2, 16'h0000, 8'h00);
		chk(flt, 1'b1);
		$display("test decode done");
	endtask : testDecode

	task automatic testStack;
		spData = 16'hfe00;
		cmd(11);
		flagData = 8'h28;
		cmd(10);
		step;
		chk(bankBase, 16'hfee0);
		cmd(2);
		waitIdle;
		chk(sp, 16'hfdff);
		access(0, 16'hfdff, 8'h00);
		chk(rd, 8'h28);
		flagData = 8'h00;
		cmd(10);
		cmd(3);
		waitIdle;
		chk(program_status_word, 8'h28);
		chk(sp, 16'hfe00);
		spData = 16'h1000;
		cmd(11);
		cmd(2);
		waitf(1, 3);
		chk(hit, 1'b1);
		waitIdle;
		spData = 16'hfe00;
		cmd(11);
		$display("test stack done");
	endtask : testStack

	task automatic testIntr;
		intSlot = 5'd2;
		intReq = 1'b1;
		waitf(0, 5);
		intReq = 1'b0;
		chk(hit, 1'b0);
		cmd(0);
		chk(program_status_word[PSW_IE], 1'b1);
		intSlot = 5'd7;
		intReq = 1'b1;
		waitf(0, 6);
		chk(hit, 1'b0);
		for (int k = 0; k < 2; k++) begin
			intSlot = 5'd2;
			intReq = 1'b1;
			waitf(0, 3);
			intReq = 1'b0;
			chk(hit, 1'b1);
			waitIdle;
			chk(pc, {expb(16'h0005), expb(16'h0004)});
			chk(program_status_word[PSW_IE], 1'b0);
			chk(sp, 16'hfdfd);
			cmd(4 + k);
			waitIdle;
			chk(pc, RAM_BASE);
			chk(program_status_word, 8'ha8);
			chk(sp, 16'hfe00);
		end
		cmd(1);
		chk(program_status_word[PSW_IE], 1'b0);
		$display("test interrupt done");
	endtask : testIntr

	task automatic testCalls;
		callTableIndex = 5'd1;
		cmd(6);
		waitIdle;
		chk(pc, {expb(16'h0043), expb(16'h0042)});
		callFixedOffset = 11'h123;
		cmd(7);
		waitIdle;
		chk(pc, 16'h0923);
		$display("test calls done");
	endtask : testCalls

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		cmdV = '0;
		{fetchReq, dataReq, dataWrite, intReq, debugActive} = '0;
		{fetchOffset, instrLen, callTableIndex, intSlot} = '0;
		{dataWdata, flagData, callFixedOffset} = '0;
		{dataAddr, branchTarget, spData} = '0;
		mismatches = 0;
		checkCount = 0;
		testReset;
		testPc;
		testDecode;
		testStack;
		testIntr;
		testCalls;
		stopTest;
	end
endmodule : cpu_memory_map_control_regs_tb_top

bind cpu_control_core cpu_control_core_monitor mon (.clk, .rst_n, .busy,
	.instrDone, .instrLen, .branchLoad, .branchTarget, .eiCmd, .intAck,
	.memAddr, .memRe, .memWe, .memWdata, .selFlash, .selRam, .selSfr, .pc,
	.program_status_word, .sp, .memSize, .bankBase, .stackFault);
